/* File: include/alias_ctrl_pkg.sv */
// Constants and types for the packed-integer issue and gating block.
// Assumes one core clock; offsets index a small plain register port.
package alias_ctrl_pkg;
	localparam logic [3:0]  REG_CTRL        = 4'h0;
	localparam logic [3:0]  REG_STATUS      = 4'h1;
	localparam logic [3:0]  REG_TAG         = 4'h2;
	localparam logic [3:0]  REG_CAUSE       = 4'h3;
	localparam int          CTRL_FEATURE    = 0;
	localparam int          CTRL_EMULATION  = 2;
	localparam logic        FEATURE_RESET   = 1'h1;
	localparam logic        EMULATION_RESET = 1'h0;
	localparam int          SW_ERROR_BIT    = 7;
	localparam int          SW_TOP_LSB      = 11;
	localparam int          SW_TOP_MSB      = 13;
	localparam logic [2:0]  TOP_CLEARED     = 3'h0;
	localparam logic [15:0] TAGS_VALID      = 16'h0000;
	localparam logic [15:0] TAGS_EMPTY      = 16'hFFFF;
	localparam int          EXP_LSB         = 64;
	localparam int          EXP_MSB         = 79;
	localparam logic [15:0] EXP_ALL_ONES    = 16'hFFFF;
	localparam logic [31:0] FEATURE_LEAF    = 32'h00000001;
	localparam int          FEATURE_EDX_BIT = 23;
	localparam logic [7:0]  NUMERIC_VECTOR  = 8'h10;
	localparam logic [31:0] READ_ZERO       = 32'h00000000;

	typedef enum logic [2:0] {
		OP_OTHER,
		OP_FP,
		OP_PACKED,
		OP_EMPTY,
		OP_QUERY,
		OP_VECTOR
	} op_class_e;

	typedef enum logic [1:0] {
		CAUSE_NONE,
		CAUSE_INVALID,
		CAUSE_NUMERIC,
		CAUSE_MEMORY
	} cause_e;

	typedef enum logic [1:0] {
		MEMF_PAGE,
		MEMF_SEG_ABSENT,
		MEMF_LIMIT
	} mem_fault_e;
endpackage : alias_ctrl_pkg

/* File: rtl/prefix_check.sv */
// Prefix screening for one packed-integer instruction.
// Assumes the decoder has already turned prefix bytes into flags.
`timescale 1ns/10ps
module prefix_check
	import alias_ctrl_pkg::*;
(
	input  wire logic lock,
	input  wire logic opsize,
	input  wire logic addrsize,
	input  wire logic segment,
	input  wire logic repeat_eq,
	input  wire logic repeat_ne,
	input  wire logic hint,
	input  wire logic has_mem,
	output logic      lock_fault,
	output logic      addr_alt,
	output logic      seg_apply,
	output logic      reserved
);
	// Reserved prefixes are only reported and otherwise ignored.
	always_comb begin
		lock_fault = lock;
		addr_alt   = addrsize & has_mem;
		seg_apply  = segment & has_mem;
		reserved   = (addrsize & ~has_mem)
			| opsize
			| (segment & ~has_mem)
			| repeat_eq | repeat_ne | hint;
	end
endmodule : prefix_check

/* File: rtl/feature_report.sv */
// Feature query result for the packed-integer group.
// Assumes the caller registers the result before it leaves the block.
`timescale 1ns/10ps
module feature_report
	import alias_ctrl_pkg::*;
(
	input  wire logic [31:0] leaf,
	input  wire logic        supported,
	output logic      [31:0] edx
);
	always_comb begin
		edx = READ_ZERO;
		if (leaf == FEATURE_LEAF) begin
			edx[FEATURE_EDX_BIT] = supported;
		end
	end
endmodule : feature_report

/* File: rtl/packed_int_fpu_alias_ctrl.sv */
// Issue gating and floating-point side effects of packed-integer work.
// Assumes one issue per cycle at most and fault inputs valid with it.
//
// How it works
// - Feature query leaf one reports bit 23.
// - Unsupported or emulation flag gives invalid opcode.
// - Packed instruction clears stack top pointer.
// - Packed instruction marks all tags valid.
// - Packed register write forces exponent ones.
// - Floating-point work leaves state untouched.
// - Empty-state instruction marks all tags empty.
// - Memory faults use the ordinary fault path.
// - No numeric fault without pending exception.
// - Pending exception faults next packed instruction.
// - Numeric-faulted instruction restarts after handler returns.
// - Packed registers share floating-point storage.
// - Address-size prefix only affects memory forms.
// - Segment override only affects memory forms.
// - Repeat and hint prefixes are reserved.
// - Lock prefix gives invalid opcode.
// - Wide vector work needs no emptying.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module packed_int_fpu_alias_ctrl
	import alias_ctrl_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        issue_valid,
	input  op_class_e        issue_class,
	input  wire logic [31:0] issue_pc,
	input  wire logic        issue_has_mem,
	input  wire logic        issue_writes_reg,
	input  wire logic [2:0]  issue_reg_idx,
	input  wire logic [63:0] issue_wdata,
	input  wire logic [31:0] issue_leaf,
	input  wire logic        pfx_lock,
	input  wire logic        pfx_opsize,
	input  wire logic        pfx_addrsize,
	input  wire logic        pfx_segment,
	input  wire logic        pfx_repeat,
	input  wire logic        pfx_repeat_ne,
	input  wire logic        pfx_hint,
	input  wire logic        mem_fault_hit,
	input  mem_fault_e       mem_fault_kind,
	input  wire logic        fp_exception_raise,
	input  wire logic        fp_wr_en,
	input  wire logic [2:0]  fp_wr_idx,
	input  wire logic [79:0] fp_wr_data,
	input  wire logic [2:0]  fp_rd_idx,
	input  wire logic [2:0]  pk_rd_idx,
	input  wire logic        handler_return,
	output logic             issue_done,
	output logic             invalid_opcode_fault,
	output logic             numeric_fault,
	output logic      [7:0]  fault_vector,
	output logic             mem_fault,
	output mem_fault_e       mem_fault_code,
	output logic             numeric_error_pin,
	output logic      [31:0] query_edx,
	output logic             addr_size_alt,
	output logic             segment_apply,
	output logic             reserved_prefix_seen,
	output logic             restart,
	output logic      [31:0] restart_pc,
	output logic      [79:0] fp_rd_data,
	output logic      [63:0] pk_rd_data,
	output logic      [2:0]  stack_top_pointer,
	output logic      [15:0] tag_word
);
	typedef struct packed {
		logic             feature;
		logic             fpu_emulation_flag;
		logic [2:0]       top;
		logic             err_pending;
		logic [15:0]      tags;
		logic [7:0][79:0] regs;
		logic [31:0]      rdata;
		logic             done;
		logic             ud;
		logic             numeric;
		logic [7:0]       vector;
		logic             memf;
		mem_fault_e       memf_code;
		logic             err_pin;
		logic [31:0]      edx;
		logic             addr_alt;
		logic             seg_apply;
		logic             reserved;
		logic             restart;
		logic [31:0]      restart_pc;
		logic             held;
		logic [31:0]      held_pc;
		cause_e           cause;
		logic [79:0]      fp_rd;
		logic [63:0]      pk_rd;
	} state_s;

	state_s      cur;
	state_s      next_cur;
	logic        lock_fault;
	logic        addr_alt;
	logic        seg_apply;
	logic        reserved;
	logic [31:0] edx_value;
	logic        is_packed;
	logic        bad_op;

	prefix_check u_prefix (
		.lock      (pfx_lock),
		.opsize    (pfx_opsize),
		.addrsize  (pfx_addrsize),
		.segment   (pfx_segment),
		.repeat_eq (pfx_repeat),
		.repeat_ne (pfx_repeat_ne),
		.hint      (pfx_hint),
		.has_mem   (issue_has_mem),
		.lock_fault(lock_fault),
		.addr_alt  (addr_alt),
		.seg_apply (seg_apply),
		.reserved  (reserved)
	);

	feature_report u_feature (
		.leaf     (issue_leaf),
		.supported(cur.feature),
		.edx      (edx_value)
	);

	// The empty-state instruction belongs to the group for every check.
	assign is_packed = issue_valid
		& ((issue_class == OP_PACKED) | (issue_class == OP_EMPTY));
	assign bad_op = ~cur.feature | cur.fpu_emulation_flag | lock_fault;

	always_comb begin
		next_cur = cur;
		next_cur.done = 1'h0;
		next_cur.ud = 1'h0;
		next_cur.numeric = 1'h0;
		next_cur.memf = 1'h0;
		next_cur.restart = 1'h0;
		next_cur.rdata = READ_ZERO;

		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: begin
					next_cur.rdata[CTRL_FEATURE] = cur.feature;
					next_cur.rdata[CTRL_EMULATION] = cur.fpu_emulation_flag;
				end
				REG_STATUS: begin
					next_cur.rdata[SW_TOP_MSB:SW_TOP_LSB] = cur.top;
					next_cur.rdata[SW_ERROR_BIT] = cur.err_pending;
				end
				REG_TAG: begin
					next_cur.rdata[15:0] = cur.tags;
				end
				REG_CAUSE: begin
					next_cur.rdata[1:0] = cur.cause;
				end
				default: begin
					next_cur.rdata = READ_ZERO;
				end
			endcase
		end

		if (reg_wr) begin
			case (reg_addr)
				REG_CTRL: begin
					next_cur.feature = reg_wdata[CTRL_FEATURE];
					next_cur.fpu_emulation_flag = reg_wdata[CTRL_EMULATION];
				end
				REG_STATUS: begin
					next_cur.top = reg_wdata[SW_TOP_MSB:SW_TOP_LSB];
					// Writing one clears the pending exception.
					if (reg_wdata[SW_ERROR_BIT]) begin
						next_cur.err_pending = 1'h0;
						next_cur.err_pin = 1'h0;
					end
				end
				REG_TAG: begin
					next_cur.tags = reg_wdata[15:0];
				end
				default: begin
					next_cur.cause = cur.cause;
				end
			endcase
		end

		// A fresh exception wins over a clear in the same cycle.
		if (fp_exception_raise) begin
			next_cur.err_pending = 1'h1;
		end

		// Floating-point writes land in the same array the packed side uses.
		if (fp_wr_en) begin
			next_cur.regs[fp_wr_idx] = fp_wr_data;
		end

		if (handler_return && cur.held) begin
			next_cur.restart = 1'h1;
			next_cur.restart_pc = cur.held_pc;
			next_cur.held = 1'h0;
		end

		if (issue_valid) begin
			next_cur.done = 1'h1;
			next_cur.addr_alt = 1'h0;
			next_cur.seg_apply = 1'h0;
			next_cur.reserved = 1'h0;
			case (issue_class)
				OP_PACKED, OP_EMPTY: begin
					next_cur.addr_alt = addr_alt;
					next_cur.seg_apply = seg_apply;
					next_cur.reserved = reserved;
					if (bad_op) begin
						// Nothing below is committed on this path.
						next_cur.ud = 1'h1;
						next_cur.cause = CAUSE_INVALID;
					end else if (cur.err_pending) begin
						next_cur.numeric = 1'h1;
						next_cur.vector = NUMERIC_VECTOR;
						next_cur.err_pin = 1'h1;
						next_cur.cause = CAUSE_NUMERIC;
						next_cur.held = 1'h1;
						next_cur.held_pc = issue_pc;
					end else if (issue_has_mem && mem_fault_hit) begin
						next_cur.memf = 1'h1;
						next_cur.memf_code = mem_fault_kind;
						next_cur.cause = CAUSE_MEMORY;
					end else if (issue_class == OP_EMPTY) begin
						next_cur.tags = TAGS_EMPTY;
					end else begin
						// Numeric faults come only from the pending path above.
						next_cur.top = TOP_CLEARED;
						next_cur.tags = TAGS_VALID;
						if (issue_writes_reg) begin
							next_cur.regs[issue_reg_idx][63:0] = issue_wdata;
							next_cur.regs[issue_reg_idx][EXP_MSB:EXP_LSB] = EXP_ALL_ONES;
						end
					end
				end
				OP_QUERY: begin
					next_cur.edx = edx_value;
				end
				OP_VECTOR: begin
					// Separate registers, so alias state is left alone.
					next_cur.top = cur.top;
				end
				OP_FP: begin
					// Stack top and tags are used exactly as found.
					next_cur.tags = cur.tags;
				end
				default: begin
					next_cur.top = cur.top;
				end
			endcase
		end

		next_cur.fp_rd = cur.regs[fp_rd_idx];
		next_cur.pk_rd = cur.regs[pk_rd_idx][63:0];
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cur <= '0;
			cur.feature <= FEATURE_RESET;
			cur.fpu_emulation_flag <= EMULATION_RESET;
			cur.tags <= TAGS_EMPTY;
			cur.cause <= CAUSE_NONE;
			cur.memf_code <= MEMF_PAGE;
		end else begin
			cur <= next_cur;
		end
	end

	// All outputs come straight from the state register.
	always_comb begin
		reg_rdata = cur.rdata;
		issue_done = cur.done;
		invalid_opcode_fault = cur.ud;
		numeric_fault = cur.numeric;
		fault_vector = cur.vector;
		mem_fault = cur.memf;
		mem_fault_code = cur.memf_code;
		numeric_error_pin = cur.err_pin;
		query_edx = cur.edx;
		addr_size_alt = cur.addr_alt;
		segment_apply = cur.seg_apply;
		reserved_prefix_seen = cur.reserved;
		restart = cur.restart;
		restart_pc = cur.restart_pc;
		fp_rd_data = cur.fp_rd;
		pk_rd_data = cur.pk_rd;
		stack_top_pointer = cur.top;
		tag_word = cur.tags;
	end
endmodule : packed_int_fpu_alias_ctrl

/* File: verification/alias_ctrl_props.sv */
// Concurrent checks on the ports of the packed-integer gating block.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/10ps
module alias_ctrl_props
	import alias_ctrl_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        issue_valid,
	input op_class_e        issue_class,
	input wire logic        pfx_lock,
	input wire logic        handler_return,
	input wire logic        issue_done,
	input wire logic        invalid_opcode_fault,
	input wire logic        numeric_fault,
	input wire logic        mem_fault,
	input wire logic [7:0]  fault_vector,
	input wire logic        numeric_error_pin,
	input wire logic        restart,
	input wire logic [2:0]  stack_top_pointer,
	input wire logic [15:0] tag_word
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	logic pk;
	assign pk = issue_valid && (issue_class == OP_PACKED || issue_class == OP_EMPTY);

	// Side effects are only owed by an issue that no fault stopped.
	sequence s_clean(op_class_e c);
		issue_valid && issue_class == c ##1 !invalid_opcode_fault && !numeric_fault && !mem_fault;
	endsequence

	a_issue_done: assert property (issue_valid |=> issue_done)
		else $error("issue without completion");
	a_lock_fault: assert property (pk && pfx_lock |=> invalid_opcode_fault)
		else $error("lock prefix not refused");
	a_fault_keeps: assert property (invalid_opcode_fault |-> $stable(tag_word) && $stable(stack_top_pointer))
		else $error("refused issue changed state");
	a_packed_state: assert property (s_clean(OP_PACKED) |-> !stack_top_pointer && tag_word == TAGS_VALID)
		else $error("packed issue state wrong");
	a_empty_tags: assert property (s_clean(OP_EMPTY) |-> tag_word == TAGS_EMPTY)
		else $error("empty issue tags wrong");
	a_fp_untouched: assert property (issue_valid && issue_class == OP_FP |=> $stable(tag_word) && $stable(stack_top_pointer))
		else $error("fp issue changed state");
	a_no_numeric: assert property (issue_valid && !pk |=> !numeric_fault)
		else $error("numeric fault on other work");
	a_numeric_vec: assert property (numeric_fault |-> fault_vector == NUMERIC_VECTOR && numeric_error_pin)
		else $error("numeric fault signalling wrong");
	a_restart_cause: assert property (restart |-> $past(handler_return))
		else $error("restart without handler return");
endmodule : alias_ctrl_props

bind packed_int_fpu_alias_ctrl alias_ctrl_props u_alias_ctrl_props (
	.clock, .rst, .issue_valid, .issue_class, .pfx_lock, .handler_return, .issue_done,
	.invalid_opcode_fault, .numeric_fault, .mem_fault, .fault_vector, .numeric_error_pin,
	.restart, .stack_top_pointer, .tag_word
);

/* File: verification/tb_packed_int_fpu_alias_ctrl.sv */
// Self-checking bench for the packed-integer gating block.
// Assumes the package constants; the register file write port is left idle.
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("mismatch %0t %h %h", $time, a, b); end end
module tb_packed_int_fpu_alias_ctrl
	import alias_ctrl_pkg::*;
;
	logic        clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, issue_valid = 0;
	logic        issue_has_mem = 0, issue_writes_reg = 0, pfx_lock = 0, pfx_opsize = 0;
	logic        pfx_addrsize = 0, pfx_segment = 0, pfx_repeat = 0, pfx_repeat_ne = 0;
	logic        pfx_hint = 0, mem_fault_hit = 0, fp_exception_raise = 0, handler_return = 0;
	logic [3:0]  reg_addr = 0;
	logic [31:0] reg_wdata = 0, issue_pc = 0, reg_rdata, query_edx, restart_pc, e, m_pc;
	logic [2:0]  issue_reg_idx = 0, fp_rd_idx = 0, pk_rd_idx = 0, stack_top_pointer, m_top = 0;
	logic [63:0] issue_wdata = 0, pk_rd_data, m_w;
	op_class_e   issue_class = OP_OTHER;
	mem_fault_e  mem_fault_kind = MEMF_PAGE, mem_fault_code, mk = MEMF_PAGE, m_code = MEMF_PAGE;
	logic        issue_done, invalid_opcode_fault, numeric_fault, mem_fault, numeric_error_pin;
	logic        addr_size_alt, segment_apply, reserved_prefix_seen, restart;
	logic [7:0]  fault_vector;
	logic [79:0] fp_rd_data;
	logic [15:0] tag_word, m_tag = 16'hFFFF;
	logic [27:0] qi[$], g;
	logic [31:0] qr[$];
	logic        rd_d = 0, m_feat = 1, m_emu = 0, m_pend = 0, m_q = 0;
	int          seed = 32'h854F1836, n_mismatch = 0, checks = 0, cyc = 0;

	packed_int_fpu_alias_ctrl u_packed_int_fpu_alias_ctrl (.fp_wr_en(1'b0), .fp_wr_idx(3'h0),
		.fp_wr_data(80'h0), .issue_leaf(FEATURE_LEAF), .*);

	always #12.5 clock = ~clock;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			stop_test();
		end
	end

	always @(posedge clock) begin
		rd_d <= reg_rd;
		if (rd_d === 1'b1) begin
			e = qr.pop_front();
			`CHK(reg_rdata, e)
		end
		if (issue_done === 1'b1) begin
			e = qi.pop_front();
			g = {query_edx[FEATURE_EDX_BIT], invalid_opcode_fault, numeric_fault, mem_fault,
				mem_fault_code, addr_size_alt, segment_apply, reserved_prefix_seen,
				stack_top_pointer, tag_word};
			`CHK(g, e[27:0])
		end
	end

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		if (a == REG_CTRL) {m_emu, m_feat} = {d[2], d[0]};
		if (a == REG_STATUS) m_top = d[13:11];
		if (a == REG_STATUS && d[7]) m_pend = 0;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] x);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		qr.push_back(x);
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask : rd

	// The model works out faults in the same priority as the hardware.
	task automatic iss(input op_class_e c, input logic lk, input logic mf);
		logic [31:0] r;
		logic [7:0]  p;
		logic        k, bad, num, mem;
		r = $random(seed);
		p = r[7:0];
		if (c != OP_PACKED || lk || !m_feat || m_emu) p = '0;
		if (mf) p[6] = 1'b1;
		k = c == OP_PACKED || c == OP_EMPTY;
		bad = k && (lk || !m_feat || m_emu);
		num = k && !bad && m_pend;
		mem = mf && !bad && !num;
		if (mem) m_code = mk;
		if (num) m_pc = r;
		if (k && !bad && !num && !mem) begin
			m_tag = (c == OP_EMPTY) ? TAGS_EMPTY : TAGS_VALID;
			if (c == OP_PACKED) {m_top, m_w} = {TOP_CLEARED, r, ~r};
		end
		if (c == OP_QUERY) m_q = m_feat;
		qi.push_back({m_q, bad, num, mem, m_code, p[1] & p[6], p[2] & p[6],
			p[0] | p[3] | p[4] | p[5] | ((p[1] | p[2]) & !p[6]), m_top, m_tag});
		@(posedge clock);
		issue_valid <= 1'b1;
		issue_class <= c;
		issue_pc <= r;
		issue_has_mem <= p[6];
		issue_writes_reg <= 1'b1;
		issue_reg_idx <= 3'h3;
		issue_wdata <= {r, ~r};
		pfx_lock <= lk;
		{pfx_hint, pfx_repeat_ne, pfx_repeat, pfx_segment, pfx_addrsize, pfx_opsize} <= p[5:0];
		mem_fault_hit <= mf;
		mem_fault_kind <= mk;
		@(posedge clock);
		issue_valid <= 1'b0;
		mem_fault_hit <= 1'b0;
	endtask : iss

	initial begin
		op_class_e cl[6] = '{OP_FP, OP_VECTOR, OP_OTHER, OP_PACKED, OP_EMPTY, OP_PACKED};
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rd(REG_TAG, {16'h0000, TAGS_EMPTY});
		rd(REG_CTRL, 32'h00000001);
		rd(4'hF, READ_ZERO);
		$display("test reset done");
		iss(OP_QUERY, 0, 0);
		wr(REG_STATUS, 32'h00002800);
		foreach (cl[i]) iss(cl[i], 0, 0);
		repeat (20) iss(OP_PACKED, 0, 0);
		@(posedge clock);
		{fp_rd_idx, pk_rd_idx} <= 6'h1B;
		repeat (2) @(posedge clock);
		`CHK(fp_rd_data, {EXP_ALL_ONES, m_w})
		`CHK(pk_rd_data, m_w)
		wr(REG_STATUS, 32'h00002800);
		iss(OP_PACKED, 1, 0);
		rd(REG_CAUSE, 32'h00000001);
		$display("test state done");
		wr(REG_CTRL, 32'h00000005);
		iss(OP_PACKED, 0, 0);
		iss(OP_EMPTY, 0, 0);
		wr(REG_CTRL, 32'h00000000);
		iss(OP_PACKED, 0, 0);
		iss(OP_QUERY, 0, 0);
		wr(REG_CTRL, 32'h00000001);
		iss(OP_QUERY, 0, 0);
		$display("test gating done");
		for (int i = 0; i < 3; i++) begin
			mk = mem_fault_e'(i);
			iss(OP_PACKED, 0, 1);
		end
		rd(REG_CAUSE, 32'h00000003);
		$display("test memory done");
		@(posedge clock);
		fp_exception_raise <= 1'b1;
		@(posedge clock);
		fp_exception_raise <= 1'b0;
		m_pend = 1;
		iss(OP_FP, 0, 0);
		iss(OP_PACKED, 0, 1);
		@(posedge clock);
		`CHK(numeric_error_pin, 1'b1)
		rd(REG_CAUSE, 32'h00000002);
		wr(REG_STATUS, 32'h00000080);
		@(posedge clock);
		`CHK(numeric_error_pin, 1'b0)
		handler_return <= 1'b1;
		@(posedge clock);
		handler_return <= 1'b0;
		@(posedge clock);
		`CHK({restart, restart_pc}, {1'b1, m_pc})
		iss(OP_PACKED, 0, 0);
		$display("test numeric done");
		repeat (4) @(posedge clock);
		stop_test();
	end
endmodule : tb_packed_int_fpu_alias_ctrl
